// [ufc_defines.vh]
// Constants for the FIFO control upper-half block.
// Assumes inclusion by bare name from the design file.
`ifndef UFC_DEFINES_VH
`define UFC_DEFINES_VH

// ==========================================
// Register indices on the plain port
`define UFC_IDX_FCR 4'h0
`define UFC_IDX_LIM 4'h1
`define UFC_IDX_STAT 4'h2

// ==========================================
// Field positions in fifo_control
`define UFC_TSE_BIT 15
`define UFC_TCC_BIT 14
`define UFC_RSV_HI 13
`define UFC_RSV_LO 11
`define UFC_RTH_HI 10
`define UFC_RTH_LO 8
`define UFC_LOW_HI 7
`define UFC_MCE_BIT 3

// ==========================================
// Field positions in the status word
`define UFC_ST_RTS_BIT 15
`define UFC_ST_CTS_BIT 14
`define UFC_ST_HALT_BIT 13
`define UFC_ST_SYNC_BIT 12

// ==========================================
// Reset values
`define UFC_FCR_RST 16'h0000
`define UFC_LIM_RST 8'hFF
`define UFC_CNT_RST 8'h00

// ==========================================
// Receive fill thresholds for RTS
`define UFC_RTH_0 7'h3F
`define UFC_RTH_1 7'h01
`define UFC_RTH_2 7'h08
`define UFC_RTH_3 7'h10
`define UFC_RTH_4 7'h20
`define UFC_RTH_5 7'h30
`define UFC_RTH_6 7'h36
`define UFC_RTH_7 7'h3C

`endif

// [ufc_fifo_ctrl.v]
// Upper half of the serial port FIFO control register, with the
// transmit stop counter and receive-fill driven RTS.
// Assumes a 250 MHz peripheral clock, a plain register port whose
// read data follow one cycle after the read strobe, and receive
// fill and transmit byte events from logic on the same clock.
// Only the CTS pin and the asynchronous reset release are synchronised in here.
// Register indices: 0 control, 1 stop limit, 2 status.
// Software must keep the stop enable clear in synchronous mode.
`timescale 1ns/1ns
`default_nettype none

`include "ufc_defines.vh"

module ufc_fifo_ctrl #(
    parameter ADDR_W = 4,
    parameter CNT_W = 8,
    parameter FILL_W = 7
) (
    input wire clk,
    input wire rst_n,
    input wire [ADDR_W-1:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire sync_mode,
    input wire [FILL_W-1:0] rx_fill_count,
    input wire tx_byte_sent,
    input wire cts_n_pin,
    output reg rts_out,
    output reg cts_active,
    output reg tx_halt,
    output reg [CNT_W-1:0] tx_count
);

    // ==========================================
    // Reset release

    // Reset synchroniser stages
    reg rst_meta_q;
    reg rst_sync_q;
    wire rst_local_n;

    // Two-stage release of the asynchronous reset
    // Entry is immediate; exit waits two edges so
    // no flop leaves reset on a metastable edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Copy used by every other flop
    assign rst_local_n = rst_sync_q;

    // ==========================================
    // Helper functions

    // Map the three-bit setting to a byte count
    // Codes 0 to 6 are listed; default supplies code 7
    function [FILL_W-1:0] ufc_thresh;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: ufc_thresh = `UFC_RTH_0;
                3'h1: ufc_thresh = `UFC_RTH_1;
                3'h2: ufc_thresh = `UFC_RTH_2;
                3'h3: ufc_thresh = `UFC_RTH_3;
                3'h4: ufc_thresh = `UFC_RTH_4;
                3'h5: ufc_thresh = `UFC_RTH_5;
                3'h6: ufc_thresh = `UFC_RTH_6;
                default: ufc_thresh = `UFC_RTH_7;
            endcase
        end
    endfunction

    // Address compare used by both strobes
    function ufc_hit;
        input [ADDR_W-1:0] addr;
        input [3:0] idx;
        begin
            ufc_hit = (addr == idx[ADDR_W-1:0]);
        end
    endfunction

    // ==========================================
    // Register storage

    // Stored control fields and stop limit
    reg tse_q;
    reg tcc_q;
    reg [2:0] rth_q;
    reg [`UFC_LOW_HI:0] low_q;
    reg [CNT_W-1:0] lim_q;

    wire wr_fcr;
    wire wr_lim;

    // Write strobes qualified by index
    assign wr_fcr = reg_wr & ufc_hit(reg_addr, `UFC_IDX_FCR);
    assign wr_lim = reg_wr & ufc_hit(reg_addr, `UFC_IDX_LIM);

    // control field storage
    // Bits 13 to 11 have no flops, so ones written
    // there can never read back; lower byte is plain
    // storage and only its modem enable acts here
    always @(posedge clk or negedge rst_local_n) begin
        if (!rst_local_n) begin
            tse_q <= 1'b0;
            tcc_q <= 1'b0;
            rth_q <= 3'h0;
            low_q <= {(`UFC_LOW_HI+1){1'b0}};
        end else if (wr_fcr) begin
            tse_q <= reg_wdata[`UFC_TSE_BIT];
            tcc_q <= reg_wdata[`UFC_TCC_BIT];
            rth_q <= reg_wdata[`UFC_RTH_HI:`UFC_RTH_LO];
            low_q <= reg_wdata[`UFC_LOW_HI:0];
        end
    end

    // Transmit stop limit, own register
    // All ones after reset: longest run before a halt
    // if software sets the stop enable without a limit
    always @(posedge clk or negedge rst_local_n) begin
        if (!rst_local_n) begin
            lim_q <= {CNT_W{1'b1}};
        end else if (wr_lim) begin
            lim_q <= reg_wdata[CNT_W-1:0];
        end
    end

    // ==========================================
    // Mode qualifiers

    wire modem_control_enable;
    wire modem_on;
    wire stop_on;

    // Modem enable sits in the plain lower byte
    assign modem_control_enable = low_q[`UFC_MCE_BIT];

    assign modem_on = modem_control_enable & ~sync_mode;

    // stop function ignored in sync
    // Masked here too, so a stray stop enable cannot
    // freeze a synchronous transfer
    assign stop_on = tse_q & ~sync_mode;

    // ==========================================
    // Transmit count

    reg [CNT_W-1:0] cnt_d;
    wire cnt_clear;
    wire cnt_take;
    wire halt_d;

    // clear only while stop enable set, sync mode or not
    // Clear is a level: count pinned at zero while
    // both upper bits stay set, bytes not counted
    assign cnt_clear = tcc_q & tse_q;

    // Byte counted only while running and not halted
    assign cnt_take = stop_on & tx_byte_sent & ~tx_halt;

    // Next count: clear beats increment
    // A byte in the clearing cycle is dropped, not half counted
    always @* begin
        cnt_d = tx_count;
        if (cnt_clear) begin
            cnt_d = {CNT_W{1'b0}};
        end else if (cnt_take) begin
            cnt_d = tx_count + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk or negedge rst_local_n) begin
        if (!rst_local_n) begin
            tx_count <= {CNT_W{1'b0}};
        end else begin
            tx_count <= cnt_d;
        end
    end

    // Halt level from the next count, so it rises on
    // the edge that counts the limiting byte
    assign halt_d = stop_on & ~cnt_clear & (cnt_d >= lim_q);

    // Halt once the count reaches the limit
    // Later bytes are refused until a clear or a new limit
    always @(posedge clk or negedge rst_local_n) begin
        if (!rst_local_n) begin
            tx_halt <= 1'b0;
        end else begin
            tx_halt <= halt_d;
        end
    end

    // ==========================================
    // CTS pin synchroniser

    // Synchroniser stages
    reg cts_meta_q;
    reg cts_sync_q;

    // Two flops before any logic reads the pin
    // Reset to one, the idle level of the active-low
    // pin, so no false grant follows reset; only the
    // second flop is read
    always @(posedge clk or negedge rst_local_n) begin
        if (!rst_local_n) begin
            cts_meta_q <= 1'b1;
            cts_sync_q <= 1'b1;
        end else begin
            cts_meta_q <= cts_n_pin;
            cts_sync_q <= cts_meta_q;
        end
    end

    // ==========================================
    // RTS and CTS outputs

    // Next RTS level
    wire rts_d;

    // falls back when fill drops
    // Fill count is on this clock; the output flop
    // below keeps the pin free of decode glitches
    assign rts_d = modem_on & (rx_fill_count >= ufc_thresh(rth_q));

    always @(posedge clk or negedge rst_local_n) begin
        if (!rst_local_n) begin
            rts_out <= 1'b0;
            cts_active <= 1'b1;
        end else begin
            rts_out <= rts_d;
            cts_active <= modem_on ? ~cts_sync_q : 1'b1;
        end
    end

    // ==========================================
    // Read path

    // Next read word
    reg [15:0] rd_d;

    // Read mux, unmapped reads return zero
    // Status word: 15 RTS, 14 CTS, 13 halt,
    // 12 synchronous mode, 7:0 transmit count
    always @* begin
        rd_d = 16'h0000;
        if (ufc_hit(reg_addr, `UFC_IDX_FCR)) begin
            rd_d[`UFC_TSE_BIT] = tse_q;
            rd_d[`UFC_TCC_BIT] = tcc_q;
            rd_d[`UFC_RSV_HI:`UFC_RSV_LO] = 3'h0;
            rd_d[`UFC_RTH_HI:`UFC_RTH_LO] = rth_q;
            rd_d[`UFC_LOW_HI:0] = low_q;
        end else if (ufc_hit(reg_addr, `UFC_IDX_LIM)) begin
            rd_d[CNT_W-1:0] = lim_q;
        end else if (ufc_hit(reg_addr, `UFC_IDX_STAT)) begin
            rd_d[`UFC_ST_RTS_BIT] = rts_out;
            rd_d[`UFC_ST_CTS_BIT] = cts_active;
            rd_d[`UFC_ST_HALT_BIT] = tx_halt;
            rd_d[`UFC_ST_SYNC_BIT] = sync_mode;
            rd_d[CNT_W-1:0] = tx_count;
        end
    end

    // data valid one cycle after strobe
    // Zero outside the answer cycle, so the port can
    // be or-ed with other peripherals on the bus
    always @(posedge clk or negedge rst_local_n) begin
        if (!rst_local_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rd_d;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule // ufc_fifo_ctrl

`default_nettype wire

// [ufc_props_properties.sv]
// Port checker for the FIFO control upper half.
// Assumes binding into ufc_fifo_ctrl with default widths.
`timescale 1ns/1ns
`default_nettype none
module ufc_props (
    input wire clk,
    input wire rst_n,
    input wire [3:0] reg_addr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire sync_mode,
    input wire [6:0] rx_fill_count,
    input wire tx_byte_sent,
    input wire cts_n_pin,
    input wire rts_out,
    input wire cts_active,
    input wire tx_halt,
    input wire [7:0] tx_count
);
    // ====
    // Properties on the port signals
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rdz; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
    a_rdz: assert property (p_rdz) else $error("read data not idle");
    property p_rsv; $past(reg_rd) && $past(reg_addr) == 4'h0 |-> reg_rdata[13:11] == 3'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_sync; sync_mode |=> !rts_out; endproperty
    a_sync: assert property (p_sync) else $error("rts in sync mode");
    property p_fill0; rx_fill_count == 7'h00 |=> !rts_out; endproperty
    a_fill0: assert property (p_fill0) else $error("rts with empty fifo");
    property p_step; $changed(tx_count) |-> tx_count == $past(tx_count) + 8'h01 || tx_count == 8'h00;
    endproperty
    a_step: assert property (p_step) else $error("count jump");
    property p_cause; $changed(tx_count) && tx_count != 8'h00 |-> $past(tx_byte_sent) && !$past(sync_mode);
    endproperty
    a_cause: assert property (p_cause) else $error("count without byte");
    property p_halt; tx_halt |=> tx_count != $past(tx_count) + 8'h01; endproperty
    a_halt: assert property (p_halt) else $error("count past halt");
    property p_cts; !cts_active |-> $past(cts_n_pin, 3); endproperty
    a_cts: assert property (p_cts) else $error("cts off without pin");
endmodule // ufc_props
bind ufc_fifo_ctrl ufc_props i_ufc_props (
    .clk(clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .sync_mode(sync_mode),
    .rx_fill_count(rx_fill_count),
    .tx_byte_sent(tx_byte_sent),
    .cts_n_pin(cts_n_pin),
    .rts_out(rts_out),
    .cts_active(cts_active),
    .tx_halt(tx_halt),
    .tx_count(tx_count)
);
`default_nettype wire

// [ufc_peer.sv]
// Remote serial peer on the flow-control lines.
// Assumes the bench clock; hold comes from the bench.
`timescale 1ns/1ns
`default_nettype none
module ufc_peer (
    input wire logic clk,
    input wire logic rts,
    input wire logic hold,
    output logic cts_n,
    output logic paused
);
    // Peer grants sending unless held off
    assign cts_n = hold;
    // Peer pauses its data while rts is high
    always @(posedge clk) begin
        paused <= rts;
    end
endmodule // ufc_peer
`default_nettype wire

// [ufc_fifo_ctrl_tb.sv]
// Bench for the FIFO control upper half: registers, RTS, count.
// Assumes the peer model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module ufc_fifo_ctrl_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sync_mode = 1'b0;
    logic [6:0] rx_fill_count = 7'h00;
    logic tx_byte_sent = 1'b0;
    logic hold = 1'b0;
    wire [15:0] reg_rdata;
    wire [7:0] tx_count;
    wire rts_out, cts_active, tx_halt, cts_n_pin, peer_paused;
    int err_count = 0;
    int checked = 0;
    logic [6:0] thr [8] = '{7'h3F, 7'h01, 7'h08, 7'h10, 7'h20, 7'h30, 7'h36, 7'h3C};
    ufc_fifo_ctrl i_ufc_fifo_ctrl (
        .clk(clk),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .sync_mode(sync_mode),
        .rx_fill_count(rx_fill_count),
        .tx_byte_sent(tx_byte_sent),
        .cts_n_pin(cts_n_pin),
        .rts_out(rts_out),
        .cts_active(cts_active),
        .tx_halt(tx_halt),
        .tx_count(tx_count)
    );
    ufc_peer i_ufc_peer (
        .clk(clk),
        .rts(rts_out),
        .hold(hold),
        .cts_n(cts_n_pin),
        .paused(peer_paused)
    );
    initial begin
        forever #2 clk = ~clk;
    end
    // ====
    // Bus and compare tasks
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", reg_rdata, exp);
    endtask
    task automatic send(input int n);
        @(posedge clk) tx_byte_sent <= 1'b1;
        repeat (n) @(posedge clk);
        tx_byte_sent <= 1'b0;
        tick(1);
    endtask
    task automatic results;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ====
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        tick(3);
        rd(4'h0, 16'h0000);
        wr(4'h0, 16'hFFFF);
        rd(4'h0, 16'hC7FF);
        rd(4'h5, 16'h0000);
        for (int s = 0; s < 8; s++) begin
            wr(4'h0, {5'h00, s[2:0], 8'h08});
            rx_fill_count <= thr[s] - 7'h01;
            tick(2);
            chk("rts below", 16'(rts_out), 16'h0000);
            @(posedge clk) rx_fill_count <= thr[s];
            tick(2);
            chk("rts at", 16'(rts_out), 16'h0001);
            @(posedge clk) rx_fill_count <= thr[s] - 7'h01;
            tick(2);
            chk("rts fall", 16'(rts_out), 16'h0000);
        end
        // Full fifo is above every threshold
        @(posedge clk) rx_fill_count <= 7'h40;
        tick(2);
        chk("rts full", 16'(rts_out), 16'h0001);
        // Stop enable is already 0 here
        @(posedge clk) sync_mode <= 1'b1;
        tick(2);
        chk("rts sync", 16'(rts_out), 16'h0000);
        @(posedge clk) sync_mode <= 1'b0;
        wr(4'h0, 16'h0700);
        @(posedge clk) hold <= 1'b1;
        tick(5);
        chk("rts off", 16'(rts_out), 16'h0000);
        chk("cts off", 16'(cts_active), 16'h0001);
        wr(4'h0, 16'h0008);
        tick(5);
        chk("cts on", 16'(cts_active), 16'h0000);
        chk("rts over", 16'(rts_out), 16'h0001);
        chk("peer paused", 16'(peer_paused), 16'h0001);
        @(posedge clk) hold <= 1'b0;
        wr(4'h1, 16'h0003);
        wr(4'h0, 16'h8000);
        send(5);
        chk("count", 16'(tx_count), 16'h0003);
        rd(4'h2, 16'h6003);
        wr(4'h0, 16'hC000);
        tick(1);
        chk("clear", {7'h00, tx_halt, tx_count}, 16'h0000);
        wr(4'h0, 16'h8000);
        send(1);
        chk("count one", 16'(tx_count), 16'h0001);
        wr(4'h0, 16'h4000);
        send(1);
        chk("no clear", 16'(tx_count), 16'h0001);
        @(posedge clk) rst_n <= 1'b0;
        tick(1);
        chk("rst count", 16'(tx_count), 16'h0000);
        @(posedge clk) rst_n <= 1'b1;
        tick(3);
        rd(4'h0, 16'h0000);
        results;
    end
endmodule // ufc_fifo_ctrl_tb
`default_nettype wire
